// ---- hdl/pabm_defs.svh ----
// Purpose: Constants for the port A/B alternate function mux
// Assumes: Included by bare name
// Notes:   Bit positions of the Port B alternate functions
`ifndef PABM_DEFS_SVH
`define PABM_DEFS_SVH
`define PABM_PB_SLAVE_SEL  0
`define PABM_PB_SCK        1
`define PABM_PB_MOSI       2
`define PABM_PB_MISO       3
`define PABM_PB_T2A        4
`define PABM_PB_T1A        5
`define PABM_PB_T1B        6
`define PABM_PB_T0A_T1C    7
`define PABM_PORT_RST      8'h00
`endif

// ---- hdl/pabm_pin_ctl.sv ----
// Purpose: Port A/B override logic and per-pin control resolution
// Assumes: Port registers and function signals are synchronous to sys_clk
// Notes:   Pin controls are registered so pad drivers see clean levels
`timescale 1ns/1ps
`include "pabm_defs.svh"

module pabm_pin_ctl
    import pabm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // Port registers and global controls
    input  wire logic [7:0]  port_a_out,
    input  wire logic [7:0]  port_a_dir,
    input  wire logic [7:0]  port_b_out,
    input  wire logic [7:0]  port_b_dir,
    input  wire logic        global_pullup_disable,
    input  wire logic        sleep_clamp,
    // External memory interface
    input  wire logic        ext_mem_enable,
    input  wire logic        mem_write_strobe,
    input  wire logic        address_active,
    input  wire logic [7:0]  mem_addr_low,
    input  wire logic [7:0]  mem_write_data,
    output logic      [7:0]  mem_read_data,
    // Timer compare outputs
    input  wire logic        timer0_match_a_out,
    input  wire logic        timer0_match_a_en,
    input  wire logic        timer1_match_c_out,
    input  wire logic        timer1_match_c_en,
    input  wire logic        timer1_match_b_out,
    input  wire logic        timer1_match_b_en,
    input  wire logic        timer1_match_a_out,
    input  wire logic        timer1_match_a_en,
    input  wire logic        timer2_match_a_out,
    input  wire logic        timer2_match_a_en,
    // SPI
    input  wire logic        spi_enable_bit,
    input  wire logic        spi_master_select,
    input  wire logic        spi_slave_data_out,
    input  wire logic        spi_master_data_out,
    input  wire logic        spi_clock_out,
    output logic             spi_master_data_in,
    output logic             spi_slave_data_in,
    output logic             spi_clock_in,
    output logic             spi_slave_select_n,
    // Pin change
    input  wire logic [7:0]  pin_change_mask,
    input  wire logic        pin_change_group0_en,
    output logic      [7:0]  pin_change_src,
    // Pads, Port A
    input  wire logic [7:0]  pad_a_in,
    output logic      [7:0]  pad_a_out,
    output logic      [7:0]  pad_a_oe,
    output logic      [7:0]  pad_a_pullup,
    output logic      [7:0]  pad_a_in_en,
    // Pads, Port B
    input  wire logic [7:0]  pad_b_in,
    output logic      [7:0]  pad_b_out,
    output logic      [7:0]  pad_b_oe,
    output logic      [7:0]  pad_b_pullup,
    output logic      [7:0]  pad_b_in_en
);

    // Per-pin override terms, Port A
    logic [7:0] a_pullup_ovr_en, a_pullup_ovr_val, a_dir_ovr_en, a_dir_ovr_val, a_value_ovr_en, a_value_ovr_val, a_in_enable_ovr_en, a_in_enable_ovr_val;
    // Per-pin override terms, Port B
    logic [7:0] b_pullup_ovr_en, b_pullup_ovr_val, b_dir_ovr_en, b_dir_ovr_val, b_value_ovr_en, b_value_ovr_val, b_in_enable_ovr_en, b_in_enable_ovr_val;
    // Resolved controls ahead of the pad registers
    logic [7:0] a_oe_next, a_out_next, a_pu_next, a_ie_next;
    logic [7:0] b_oe_next, b_out_next, b_pu_next, b_ie_next;
    logic [7:0] a_oe_reg, a_out_reg, a_pu_reg, a_ie_reg;
    logic [7:0] b_oe_reg, b_out_reg, b_pu_reg, b_ie_reg;
    logic [7:0] rd_data_reg;
    logic [7:0] pcint_reg;
    logic [3:0] spi_in_reg;
    logic       mem_drive;
    logic       spi_master;
    logic       spi_slave;
    logic       b7_en;
    logic       b7_val;
    pabm_b7_src_type b7_src;

    // Memory phase: drive on write strobe or while address is presented
    assign mem_drive = mem_write_strobe | address_active;

    // Port A overrides, all eight pins alike
    assign a_pullup_ovr_en  = {8{ext_mem_enable}};
    assign a_dir_ovr_en  = {8{ext_mem_enable}};
    assign a_value_ovr_en  = {8{ext_mem_enable}};
    assign a_in_enable_ovr_en = 8'h00;
    assign a_in_enable_ovr_val = 8'h00;
    assign a_dir_ovr_val  = {8{mem_drive}};
    // Pull-up follows port bit only while the bus is not driven and global_pullup_disable is set
    assign a_pullup_ovr_val  = {8{~mem_drive}} & port_a_out & {8{global_pullup_disable}};
    // Address during address phase, write data during write strobe
    assign a_value_ovr_val  = (mem_addr_low & {8{address_active}})
                   | (mem_write_data & {8{mem_write_strobe}});

    // SPI role decode
    assign spi_master = spi_enable_bit & spi_master_select;
    assign spi_slave  = spi_enable_bit & ~spi_master_select;

    // Bit 7 picks timer 1 C when that compare is enabled, else timer 0 A
    assign b7_src = timer1_match_c_en ? PABM_B7_TIMER1 : PABM_B7_TIMER0;
    assign b7_en  = timer0_match_a_en | timer1_match_c_en;
    assign b7_val = (b7_src == PABM_B7_TIMER1) ? timer1_match_c_out
                                               : timer0_match_a_out;

    // Port B overrides; compare outputs only replace the value, so dir bit gates them
    assign b_value_ovr_en[`PABM_PB_T0A_T1C] = b7_en;
    assign b_value_ovr_val[`PABM_PB_T0A_T1C] = b7_val;
    assign b_value_ovr_en[`PABM_PB_T1B]     = timer1_match_b_en;
    assign b_value_ovr_val[`PABM_PB_T1B]     = timer1_match_b_out;
    assign b_value_ovr_en[`PABM_PB_T1A]     = timer1_match_a_en;
    assign b_value_ovr_val[`PABM_PB_T1A]     = timer1_match_a_out;
    assign b_value_ovr_en[`PABM_PB_T2A]     = timer2_match_a_en;
    assign b_value_ovr_val[`PABM_PB_T2A]     = timer2_match_a_out;
    // Forced inputs: MISO in master, MOSI, clock and slave select in slave
    assign b_dir_ovr_en[`PABM_PB_MISO]      = spi_master;
    assign b_dir_ovr_en[`PABM_PB_MOSI]      = spi_slave;
    assign b_dir_ovr_en[`PABM_PB_SCK]       = spi_slave;
    assign b_dir_ovr_en[`PABM_PB_SLAVE_SEL] = spi_slave;
    assign b_dir_ovr_en[7:4] = 4'h0;
    assign b_dir_ovr_val      = 8'h00;
    // Forced inputs keep the port-bit pull-up, still honouring the disable term
    assign b_pullup_ovr_en = b_dir_ovr_en;
    assign b_pullup_ovr_val = port_b_out & ~{8{global_pullup_disable}} & b_dir_ovr_en;
    // Master drives MOSI and clock; slave drives MISO when its dir bit allows
    assign b_value_ovr_en[`PABM_PB_MISO]      = spi_slave;
    assign b_value_ovr_val[`PABM_PB_MISO]      = spi_slave_data_out;
    assign b_value_ovr_en[`PABM_PB_MOSI]      = spi_master;
    assign b_value_ovr_val[`PABM_PB_MOSI]      = spi_master_data_out;
    assign b_value_ovr_en[`PABM_PB_SCK]       = spi_master;
    assign b_value_ovr_val[`PABM_PB_SCK]       = spi_clock_out;
    assign b_value_ovr_en[`PABM_PB_SLAVE_SEL] = 1'b0;
    assign b_value_ovr_val[`PABM_PB_SLAVE_SEL] = 1'b0;
    // Enabled change sources keep their input alive through sleep
    assign b_in_enable_ovr_en = pin_change_mask & {8{pin_change_group0_en}};
    assign b_in_enable_ovr_val = 8'hFF;

    // Resolution: each override replaces only its own control
    assign a_oe_next  = (a_dir_ovr_en & a_dir_ovr_val) | (~a_dir_ovr_en & port_a_dir);
    assign a_out_next = (a_value_ovr_en & a_value_ovr_val) | (~a_value_ovr_en & port_a_out);
    assign a_pu_next  = (a_pullup_ovr_en & a_pullup_ovr_val)
                      | (~a_pullup_ovr_en & ~port_a_dir & port_a_out
                         & ~{8{global_pullup_disable}});
    assign a_ie_next  = (a_in_enable_ovr_en & a_in_enable_ovr_val) | (~a_in_enable_ovr_en & {8{~sleep_clamp}});
    assign b_oe_next  = (b_dir_ovr_en & b_dir_ovr_val) | (~b_dir_ovr_en & port_b_dir);
    assign b_out_next = (b_value_ovr_en & b_value_ovr_val) | (~b_value_ovr_en & port_b_out);
    assign b_pu_next  = (b_pullup_ovr_en & b_pullup_ovr_val)
                      | (~b_pullup_ovr_en & ~port_b_dir & port_b_out
                         & ~{8{global_pullup_disable}});
    assign b_ie_next  = (b_in_enable_ovr_en & b_in_enable_ovr_val) | (~b_in_enable_ovr_en & {8{~sleep_clamp}});

    // Pad control registers; clk_en freezes them
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            a_oe_reg  <= `PABM_PORT_RST;
            a_out_reg <= `PABM_PORT_RST;
            a_pu_reg  <= `PABM_PORT_RST;
            a_ie_reg  <= `PABM_PORT_RST;
        end else if (clk_en) begin
            a_oe_reg  <= a_oe_next;
            a_out_reg <= a_out_next;
            a_pu_reg  <= a_pu_next;
            a_ie_reg  <= a_ie_next;
        end
    end

    // Port B pad registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            b_oe_reg  <= `PABM_PORT_RST;
            b_out_reg <= `PABM_PORT_RST;
            b_pu_reg  <= `PABM_PORT_RST;
            b_ie_reg  <= `PABM_PORT_RST;
        end else if (clk_en) begin
            b_oe_reg  <= b_oe_next;
            b_out_reg <= b_out_next;
            b_pu_reg  <= b_pu_next;
            b_ie_reg  <= b_ie_next;
        end
    end

    // Inputs to functions; a disabled input reads as zero, like a clamped pad, except the SPI inputs, which read as one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data_reg <= `PABM_PORT_RST;
            pcint_reg   <= `PABM_PORT_RST;
            spi_in_reg  <= 4'hF;
        end else if (clk_en) begin
            rd_data_reg <= pad_a_in & a_ie_reg;
            pcint_reg   <= pad_b_in & b_ie_reg;
            spi_in_reg  <= pad_b_in[3:0] | ~b_ie_reg[3:0];
        end
    end

    // Outputs
    assign pad_a_out          = a_out_reg;
    assign pad_a_oe           = a_oe_reg;
    assign pad_a_pullup       = a_pu_reg;
    assign pad_a_in_en        = a_ie_reg;
    assign pad_b_out          = b_out_reg;
    assign pad_b_oe           = b_oe_reg;
    assign pad_b_pullup       = b_pu_reg;
    assign pad_b_in_en        = b_ie_reg;
    assign mem_read_data      = rd_data_reg;
    assign pin_change_src     = pcint_reg;
    assign spi_slave_select_n = spi_in_reg[`PABM_PB_SLAVE_SEL];
    assign spi_clock_in       = spi_in_reg[`PABM_PB_SCK];
    assign spi_slave_data_in  = spi_in_reg[`PABM_PB_MOSI];
    assign spi_master_data_in = spi_in_reg[`PABM_PB_MISO];

    // Memory mode drives Port A exactly when the bus phase asks for it
    property p_mem_oe;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && ext_mem_enable) |=> (pad_a_oe == {8{$past(mem_drive)}});
    endproperty
    a_mem_oe: assert property (p_mem_oe) else $error("port A oe wrong");

    property p_mem_in_en;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && ext_mem_enable && sleep_clamp) |=> (pad_a_in_en == 8'h00);
    endproperty
    a_mem_in_en: assert property (p_mem_in_en) else $error("input override used");

    property p_addr_out;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && ext_mem_enable && address_active && !mem_write_strobe)
            |=> (pad_a_out == $past(mem_addr_low));
    endproperty
    a_addr_out: assert property (p_addr_out) else $error("address not driven");

    property p_miso_in;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && spi_master) |=> !pad_b_oe[`PABM_PB_MISO];
    endproperty
    a_miso_in: assert property (p_miso_in) else $error("MISO not input");

    property p_mosi_in;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && spi_slave) |=> !pad_b_oe[`PABM_PB_MOSI] && !pad_b_oe[`PABM_PB_SCK];
    endproperty
    a_mosi_in: assert property (p_mosi_in) else $error("slave pins not input");

    property p_pwm5;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && timer1_match_a_en) |=> (pad_b_out[`PABM_PB_T1A] == $past(timer1_match_a_out));
    endproperty
    a_pwm5: assert property (p_pwm5) else $error("bit 5 compare lost");

    property p_pcint_ie;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && pin_change_group0_en && pin_change_mask[7]) |=> pad_b_in_en[7];
    endproperty
    a_pcint_ie: assert property (p_pcint_ie) else $error("input not forced on");

    property p_pullup;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && !ext_mem_enable && !port_a_dir[0] && port_a_out[0] && !global_pullup_disable)
            |=> pad_a_pullup[0];
    endproperty
    a_pullup: assert property (p_pullup) else $error("default pull-up off");

    // Write strobe alone puts the write data on the pins
    property p_wr_out;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && ext_mem_enable && mem_write_strobe && !address_active)
            |=> (pad_a_out == $past(mem_write_data));
    endproperty
    a_wr_out: assert property (p_wr_out) else $error("write data not driven");

    // A driven bus must never fight a pull-up
    property p_bus_pullup;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && ext_mem_enable && mem_drive) |=> (pad_a_pullup == 8'h00);
    endproperty
    a_bus_pullup: assert property (p_bus_pullup) else $error("bus pull-up on");

    // Read data is the enabled pin level one cycle later
    property p_rd_data;
        @(posedge sys_clk) disable iff (rst)
        clk_en |=> (mem_read_data == ($past(pad_a_in) & $past(pad_a_in_en)));
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data wrong");

    // Timer 1 C owns bit 7 whenever its compare output is on
    property p_b7_t1c;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && timer1_match_c_en)
            |=> (pad_b_out[`PABM_PB_T0A_T1C] == $past(timer1_match_c_out));
    endproperty
    a_b7_t1c: assert property (p_b7_t1c) else $error("bit 7 timer 1 lost");

    // Otherwise timer 0 A reaches bit 7
    property p_b7_t0a;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && timer0_match_a_en && !timer1_match_c_en)
            |=> (pad_b_out[`PABM_PB_T0A_T1C] == $past(timer0_match_a_out));
    endproperty
    a_b7_t0a: assert property (p_b7_t0a) else $error("bit 7 timer 0 lost");

    // Bit 6 follows timer 1 B waveform
    property p_pwm6;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && timer1_match_b_en)
            |=> (pad_b_out[`PABM_PB_T1B] == $past(timer1_match_b_out));
    endproperty
    a_pwm6: assert property (p_pwm6) else $error("bit 6 compare lost");

    // Bit 4 follows timer 2 A waveform
    property p_pwm4;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && timer2_match_a_en)
            |=> (pad_b_out[`PABM_PB_T2A] == $past(timer2_match_a_out));
    endproperty
    a_pwm4: assert property (p_pwm4) else $error("bit 4 compare lost");

    // A slave must listen on its select pin, never drive it
    property p_ss_in;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && spi_slave) |=> !pad_b_oe[`PABM_PB_SLAVE_SEL];
    endproperty
    a_ss_in: assert property (p_ss_in) else $error("select not input");

    // Forced input keeps the port-bit pull-up
    property p_spi_pullup;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && spi_master) |=> (pad_b_pullup[`PABM_PB_MISO]
            == ($past(port_b_out[`PABM_PB_MISO]) && !$past(global_pullup_disable)));
    endproperty
    a_spi_pullup: assert property (p_spi_pullup) else $error("pull-up lost");

endmodule // pabm_pin_ctl

// ---- hdl/pabm_pkg.sv ----
// Purpose: Types for the port A/B alternate function mux
// Assumes: Nothing
// Notes:   Types only; constants sit in the defs header
package pabm_pkg;
    typedef logic [7:0] pabm_byte_type;
    // Selection of the timer driving Port B bit 7
    typedef enum logic [1:0] {
        PABM_B7_TIMER0 = 2'h1,
        PABM_B7_TIMER1 = 2'h2
    } pabm_b7_src_type;
endpackage

// ---- tb/pabm_pin_model.sv ----
// Purpose: Pin-level partner standing for the memory device and SPI peers
// Assumes: Pad controls come from pabm_pin_ctl; the bench says what outside drives
// Notes:   An undriven pin with no pull-up toggles each cycle, so stale data never looks valid
`timescale 1ns/1ps

module pabm_pin_model (
    // Clock
    input  wire logic       sys_clk,
    // Pad controls from the device
    input  wire logic [7:0] pad_a_out,
    input  wire logic [7:0] pad_a_oe,
    input  wire logic [7:0] pad_a_pullup,
    input  wire logic [7:0] pad_b_out,
    input  wire logic [7:0] pad_b_oe,
    input  wire logic [7:0] pad_b_pullup,
    // Outside drivers
    input  wire logic [7:0] ext_a_val,
    input  wire logic [7:0] ext_a_en,
    input  wire logic [7:0] ext_b_val,
    input  wire logic [7:0] ext_b_en,
    // Resolved pin levels
    output logic      [7:0] pad_a_in,
    output logic      [7:0] pad_b_in
);
    logic [7:0] float_reg = 8'h55;

    // Floating level changes every cycle
    always_ff @(posedge sys_clk) begin
        float_reg <= ~float_reg;
    end

    // Device drive wins, then the outside party, then the pull-up, else floating
    // Floating level is an argument so the pins follow it as it changes
    function automatic logic [7:0] wire_level(input logic [7:0] oe, out, en, val, pu, flt);
        return (oe & out) | (~oe & ((en & val) | (~en & (pu | flt))));
    endfunction

    assign pad_a_in = wire_level(pad_a_oe, pad_a_out, ext_a_en, ext_a_val, pad_a_pullup,
                                 float_reg);
    assign pad_b_in = wire_level(pad_b_oe, pad_b_out, ext_b_en, ext_b_val, pad_b_pullup,
                                 float_reg);
endmodule // pabm_pin_model

// ---- tb/port_a_b_alternate_function_mux_bench.sv ----
// Purpose: Self-checking bench for the port A/B override logic
// Assumes: Pad controls are registered, function inputs settle within three cycles
// Notes:   Inputs change on the falling edge so the rising edge samples clean values
`timescale 1ns/1ps

module port_a_b_alternate_function_mux_bench;
    import pabm_pkg::*;
    int err_total = 0;
    int n_checks = 0;
    logic sys_clk = 1'b0, rst = 1'b1, sleep_clamp = 1'b0, global_pullup_disable = 1'b0;
    logic clk_en = 1'b1;
    logic ext_mem_enable = 1'b0, mem_write_strobe = 1'b0, address_active = 1'b0;
    logic spi_enable_bit = 1'b0, spi_master_select = 1'b0, spi_slave_data_out = 1'b0;
    logic spi_master_data_out = 1'b0, spi_clock_out = 1'b0, pin_change_group0_en = 1'b0;
    logic [4:0] tm_out = 5'h00, tm_en = 5'h00; // Timer 0A, 1C, 1B, 1A, 2A from top
    pabm_byte_type port_a_out = 8'h00, port_a_dir = 8'h00, port_b_out = 8'h00;
    pabm_byte_type port_b_dir = 8'h00, mem_addr_low = 8'h00, mem_write_data = 8'h00;
    pabm_byte_type pin_change_mask = 8'h00, ext_a_val = 8'h00, ext_a_en = 8'h00;
    pabm_byte_type ext_b_val = 8'h00, ext_b_en = 8'h00;
    pabm_byte_type mem_read_data, pin_change_src, pad_a_in, pad_a_out, pad_a_oe, pad_a_pullup;
    pabm_byte_type pad_a_in_en, pad_b_in, pad_b_out, pad_b_oe, pad_b_pullup, pad_b_in_en;
    logic spi_master_data_in, spi_slave_data_in, spi_clock_in, spi_slave_select_n;

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    pabm_pin_ctl dut (.sys_clk, .rst, .clk_en, .port_a_out, .port_a_dir, .port_b_out,
        .port_b_dir, .global_pullup_disable, .sleep_clamp, .ext_mem_enable, .mem_write_strobe,
        .address_active, .mem_addr_low, .mem_write_data, .mem_read_data,
        .timer0_match_a_out(tm_out[4]), .timer0_match_a_en(tm_en[4]),
        .timer1_match_c_out(tm_out[3]), .timer1_match_c_en(tm_en[3]),
        .timer1_match_b_out(tm_out[2]), .timer1_match_b_en(tm_en[2]),
        .timer1_match_a_out(tm_out[1]), .timer1_match_a_en(tm_en[1]),
        .timer2_match_a_out(tm_out[0]), .timer2_match_a_en(tm_en[0]),
        .spi_enable_bit, .spi_master_select, .spi_slave_data_out, .spi_master_data_out,
        .spi_clock_out, .spi_master_data_in, .spi_slave_data_in, .spi_clock_in,
        .spi_slave_select_n, .pin_change_mask, .pin_change_group0_en, .pin_change_src,
        .pad_a_in, .pad_a_out, .pad_a_oe, .pad_a_pullup, .pad_a_in_en,
        .pad_b_in, .pad_b_out, .pad_b_oe, .pad_b_pullup, .pad_b_in_en);

    pabm_pin_model partner (.sys_clk, .pad_a_out, .pad_a_oe, .pad_a_pullup, .pad_b_out,
        .pad_b_oe, .pad_b_pullup, .ext_a_val, .ext_a_en, .ext_b_val, .ext_b_en,
        .pad_a_in, .pad_b_in);

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Pad controls take one cycle, function inputs two; three covers both
    task automatic settle();
        repeat (3) @(negedge sys_clk);
    endtask

    task automatic complete_run();
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic t_mem_cycle();
        ext_mem_enable = 1'b1;
        address_active = 1'b1;
        mem_addr_low = 8'hA5;
        mem_write_data = 8'h3C;
        port_a_out = 8'hFF;
        global_pullup_disable = 1'b1;
        settle();
        chk(pad_a_oe, 8'hFF, "addr oe");
        chk(pad_a_out, 8'hA5, "addr out");
        chk(pad_a_pullup, 8'h00, "addr pullup");
        chk(pad_a_in_en, 8'hFF, "addr in_en");
        address_active = 1'b0;
        mem_write_strobe = 1'b1;
        settle();
        chk(pad_a_oe, 8'hFF, "write oe");
        chk(pad_a_out, 8'h3C, "write out");
        mem_write_strobe = 1'b0;
        port_a_out = 8'h96;
        ext_a_en = 8'hFF;
        ext_a_val = 8'h5C;
        settle();
        chk(pad_a_oe, 8'h00, "read oe");
        chk(pad_a_pullup, 8'h96, "read pullup");
        chk(mem_read_data, 8'h5C, "read data");
        sleep_clamp = 1'b1;
        settle();
        chk(pad_a_in_en, 8'h00, "bus sleep in_en");
        chk(mem_read_data, 8'h00, "bus sleep data");
        sleep_clamp = 1'b0;
        ext_a_en = 8'h00;
    endtask

    task automatic t_mem_off();
        ext_mem_enable = 1'b0;
        address_active = 1'b1;
        global_pullup_disable = 1'b0;
        port_a_dir = 8'h0F;
        port_a_out = 8'h3C;
        settle();
        chk(pad_a_oe, 8'h0F, "gpio oe");
        chk(pad_a_out, 8'h3C, "gpio out");
        chk(pad_a_pullup, 8'h30, "gpio pullup");
        address_active = 1'b0;
    endtask

    task automatic t_freeze_reset();
        clk_en = 1'b0;
        port_a_dir = 8'hF0;
        settle();
        chk(pad_a_oe, 8'h0F, "frozen oe");
        clk_en = 1'b1;
        settle();
        chk(pad_a_oe, 8'hF0, "thawed oe");
        rst = 1'b1;
        settle();
        chk(pad_a_oe, 8'h00, "reset oe");
        chk({7'h00, spi_slave_select_n}, 8'h01, "reset select");
        rst = 1'b0;
        @(negedge sys_clk);
        chk(pad_a_oe, 8'hF0, "first oe after reset");
    endtask

    task automatic t_timers();
        port_b_dir = 8'hF0;
        tm_en = 5'h1F;
        tm_out = 5'b01101;
        settle();
        chk(pad_b_oe & 8'hF0, 8'hF0, "cmp oe");
        chk(pad_b_out & 8'hF0, 8'hD0, "cmp out");
        tm_en[3] = 1'b0;
        tm_out = 5'b10010;
        settle();
        chk(pad_b_out & 8'hF0, 8'hA0, "pwm out");
        port_b_dir = 8'h00;
        settle();
        chk(pad_b_oe & 8'hF0, 8'h00, "cmp dir off");
    endtask

    task automatic t_spi();
        spi_enable_bit = 1'b1;
        spi_master_select = 1'b1;
        port_b_dir = 8'h0F;
        port_b_out = 8'h0F;
        spi_master_data_out = 1'b1;
        ext_b_en = 8'h08;
        ext_b_val = 8'h00;
        settle();
        chk(pad_b_oe & 8'h0F, 8'h07, "master oe");
        chk(pad_b_out & 8'h06, 8'h04, "master out");
        chk(pad_b_pullup & 8'h08, 8'h08, "master pullup");
        chk({7'h00, spi_master_data_in}, 8'h00, "master miso in");
        spi_master_select = 1'b0;
        ext_b_en = 8'h07;
        ext_b_val = 8'h02;
        settle();
        chk(pad_b_oe & 8'h0F, 8'h08, "slave oe");
        chk(pad_b_pullup & 8'h07, 8'h07, "slave pullup");
        chk({7'h00, spi_slave_select_n}, 8'h00, "slave select");
        chk({7'h00, spi_clock_in}, 8'h01, "slave clock");
        chk({7'h00, spi_slave_data_in}, 8'h00, "slave mosi in");
        chk(pad_b_out & 8'h08, 8'h00, "slave miso out");
        spi_enable_bit = 1'b0;
    endtask

    task automatic t_pin_change();
        port_b_dir = 8'h00;
        ext_b_en = 8'hFF;
        ext_b_val = 8'hA5;
        sleep_clamp = 1'b1;
        pin_change_group0_en = 1'b1;
        pin_change_mask = 8'hFE;
        settle();
        chk(pad_b_in_en, 8'hFE, "wake in_en");
        chk(pin_change_src, 8'hA4, "wake src");
        pin_change_group0_en = 1'b0;
        settle();
        chk(pad_b_in_en, 8'h00, "sleep in_en");
        sleep_clamp = 1'b0;
        settle();
        chk(pin_change_src, 8'hA5, "awake src");
    endtask

    // Guard against a hung run
    initial begin
        repeat (2000) @(negedge sys_clk);
        err_total++;
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        t_mem_cycle();
        t_mem_off();
        t_freeze_reset();
        t_timers();
        t_spi();
        t_pin_change();
        complete_run();
    end
endmodule // port_a_b_alternate_function_mux_bench
